// >>> hdl/cmd_port.sv
`timescale 1ns/1ps
`include "cmd_port_defs.svh"

// simple ring fifo, honest full and empty
module txq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [LW-1:0] cnt;
  } fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_st_t s_ff;
  fifo_st_t nxt_s;
  logic do_wr;
  logic do_rd;

  assign in_ready = (s_ff.cnt != LW'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data = mem[s_ff.rptr];
  assign level = s_ff.cnt;
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    nxt_s = s_ff;
    if (do_wr) begin
      nxt_s.wptr = (s_ff.wptr == AW'(DEPTH-1)) ? '0 : s_ff.wptr + 1'b1;
    end
    if (do_rd) begin
      nxt_s.rptr = (s_ff.rptr == AW'(DEPTH-1)) ? '0 : s_ff.rptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  // storage
  always_ff @(posedge core_clk) begin
    if (clk_en && do_wr) begin
      mem[s_ff.wptr] <= in_data;
    end
  end
endmodule

module usb_device_command_port (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic bus16,
  input wire cmd_port_pkg::bus_req_t req,
  output cmd_port_pkg::bus_rsp_t rsp_ff,
  output logic buf_ready_ff,
  output logic tx_valid,
  input wire logic tx_ready,
  output cmd_port_pkg::ep_byte_t tx_data,
  input wire logic rx_valid,
  output logic rx_ready_ff,
  input wire cmd_port_pkg::ep_byte_t rx_data,
  output cmd_port_pkg::dev_cfg_t cfg_ff,
  output logic [15:0] stall_ff,
  output logic [15:0] ep_enable_ff
);
  localparam int LVW = $clog2(`TXQ_DEPTH+1);

  cmd_port_pkg::state_t s_ff;
  cmd_port_pkg::state_t nxt_s;
  logic [7:0] rx_mem [`RXBUF_BYTES];
  logic push_v;
  cmd_port_pkg::ep_byte_t push_d;
  logic [LVW-1:0] txq_level;
  logic rx_take;

  // power-on and F6 state
  function automatic cmd_port_pkg::state_t rst_state();
    cmd_port_pkg::state_t r;
    r = '0;
    r.tgt = cmd_port_pkg::T_NONE;
    for (int i = 0; i < 16; i++) begin
      r.epcfg[i] = `RST_EPCFG;
    end
    r.cfg.addr = `RST_ADDR;
    r.cfg.mode = `RST_MODE;
    r.cfg.hw = `RST_HW;
    r.cfg.irq = `RST_IRQ;
    r.cfg.dmac = `RST_DMAC;
    r.cfg.dcnt = `RST_DCNT;
    r.rxrdy = 1'b1;
    r.bufrdy = 1'b1;
    return r;
  endfunction

  // command code to target
  function automatic cmd_port_pkg::tgt_t tgt_of(input logic [7:0] c);
    if (c == `CMD_BUF_W_BAD || c == `CMD_BUF_R_BAD) begin
      return cmd_port_pkg::T_NONE;
    end
    unique case (c[7:4])
      `GRP_BUF_W, `GRP_BUF_R: return cmd_port_pkg::T_BUF;
      `GRP_CFG_W, `GRP_CFG_R: return cmd_port_pkg::T_EPCFG;
      default: begin
      end
    endcase
    unique case (c)
      `CMD_STAT0, `CMD_STAT1: return cmd_port_pkg::T_STAT;
      `CMD_ADDR_W, `CMD_ADDR_R: return cmd_port_pkg::T_ADDR;
      `CMD_MODE_W, `CMD_MODE_R: return cmd_port_pkg::T_MODE;
      `CMD_HW_W, `CMD_HW_R: return cmd_port_pkg::T_HW;
      `CMD_IRQ_W, `CMD_IRQ_R: return cmd_port_pkg::T_IRQ;
      `CMD_DMAC_W, `CMD_DMAC_R: return cmd_port_pkg::T_DMAC;
      `CMD_DCNT_W, `CMD_DCNT_R: return cmd_port_pkg::T_DCNT;
      default: return cmd_port_pkg::T_NONE;
    endcase
  endfunction

  // write-direction codes
  function automatic logic is_wr(input logic [7:0] c);
    return (c[7:4] == `GRP_BUF_W) || (c[7:4] == `GRP_CFG_W) ||
           ((c[7:4] >= `GRP_GEN) && !c[0]);
  endfunction

  // register width in bytes
  function automatic logic [2:0] width_of(input cmd_port_pkg::tgt_t t);
    unique case (t)
      cmd_port_pkg::T_HW, cmd_port_pkg::T_DMAC, cmd_port_pkg::T_DCNT: return `W_HALF;
      cmd_port_pkg::T_IRQ: return `W_WORD;
      default: return `W_BYTE;
    endcase
  endfunction

  // current value of the selected register
  function automatic logic [31:0] reg_val(input cmd_port_pkg::state_t st);
    logic [7:0] stat;
    stat = '0;
    stat[`STAT_STALL_BIT] = st.stall[st.ep];
    stat[`STAT_FULL_BIT] = st.rx_full && (st.rx_ep == st.ep);
    unique case (st.tgt)
      cmd_port_pkg::T_EPCFG: return {24'h00_0000, st.epcfg[st.ep]};
      cmd_port_pkg::T_ADDR: return {24'h00_0000, st.cfg.addr};
      cmd_port_pkg::T_MODE: return {24'h00_0000, st.cfg.mode};
      cmd_port_pkg::T_HW: return {16'h0000, st.cfg.hw};
      cmd_port_pkg::T_IRQ: return st.cfg.irq;
      cmd_port_pkg::T_DMAC: return {16'h0000, st.cfg.dmac};
      cmd_port_pkg::T_DCNT: return {16'h0000, st.cfg.dcnt};
      cmd_port_pkg::T_STAT: return {24'h00_0000, stat};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // byte of the OUT buffer image: length first, then payload
  function automatic logic [7:0] buf_byte(input logic [10:0] pos);
    logic [15:0] blen;
    logic [10:0] off;
    blen = (s_ff.rx_full && s_ff.rx_ep == s_ff.ep) ? s_ff.rx_len : 16'h0000;
    off = pos - `LEN_BYTES;
    if (pos == 11'h000) begin
      return blen[7:0];
    end else if (pos == 11'h001) begin
      return blen[15:8];
    end else if ({5'h00, off} < blen) begin
      return rx_mem[off[9:0]];
    end
    return 8'h00;
  endfunction

  // next-state logic
  always_comb begin
    logic buf_wr;
    logic bv;
    logic [7:0] b;
    logic [31:0] wval;
    logic [2:0] wid;
    logic [2:0] p;
    logic [10:0] step;
    logic [10:0] top;
    logic [15:0] rb;
    logic [7:0] c;
    buf_wr = 1'b0;
    bv = 1'b0;
    b = 8'h00;
    wid = width_of(s_ff.tgt);
    wval = reg_val(s_ff);
    p = '0;
    step = bus16 ? 11'h002 : 11'h001;
    top = s_ff.idx + step - 11'h001;
    rb = 16'h0000;
    c = req.data[7:0];
    nxt_s = s_ff;
    nxt_s.rsp.valid = 1'b0;
    push_v = 1'b0;
    push_d = '0;
    rx_take = rx_valid & s_ff.rxrdy;

    // IN buffer write, one byte a cycle; upper byte waits a cycle
    buf_wr = req.wr && !req.sel && s_ff.wr_dir && !s_ff.pend_v &&
             (s_ff.tgt == cmd_port_pkg::T_BUF) &&
             s_ff.epcfg[s_ff.ep][`EPCFG_EN_BIT];
    bv = buf_wr || s_ff.pend_v;
    b = s_ff.pend_v ? s_ff.pend_b : req.data[7:0];
    nxt_s.pend_v = buf_wr && bus16;
    nxt_s.pend_b = req.data[15:8];
    if (bv) begin
      nxt_s.idx = s_ff.idx + 11'h001;
      if (s_ff.idx == 11'h000) begin
        nxt_s.len[7:0] = b;
      end else if (s_ff.idx == 11'h001) begin
        nxt_s.len[15:8] = b;
      end else if (s_ff.cnt < s_ff.len) begin
        push_v = 1'b1;
        push_d.ep = s_ff.ep;
        push_d.last = (s_ff.cnt == s_ff.len - 16'h0001);
        push_d.data = b;
        nxt_s.cnt = s_ff.cnt + 16'h0001;
      end
    end

    // register write in the data phase
    if (req.wr && !req.sel && s_ff.wr_dir && (s_ff.tgt != cmd_port_pkg::T_BUF)) begin
      for (int k = 0; k < 2; k++) begin
        p = {1'b0, s_ff.idx[1:0]} + 3'(k);
        if ((k == 0 || bus16) && p < wid && s_ff.idx < 11'h004) begin
          wval[{p[1:0], 3'b000} +: 8] = req.data[8*k +: 8];
        end
      end
      nxt_s.idx = s_ff.idx + step;
      unique case (s_ff.tgt)
        cmd_port_pkg::T_EPCFG: nxt_s.epcfg[s_ff.ep] = wval[7:0];
        cmd_port_pkg::T_ADDR: nxt_s.cfg.addr = wval[7:0];
        cmd_port_pkg::T_MODE: nxt_s.cfg.mode = wval[7:0];
        cmd_port_pkg::T_HW: nxt_s.cfg.hw = wval[15:0];
        cmd_port_pkg::T_IRQ: nxt_s.cfg.irq = wval;
        cmd_port_pkg::T_DMAC: nxt_s.cfg.dmac = wval[15:0];
        cmd_port_pkg::T_DCNT: nxt_s.cfg.dcnt = wval[15:0];
        default: begin
        end
      endcase
    end

    // data-phase read, answered one cycle later
    if (req.rd && !req.sel) begin
      nxt_s.rsp.valid = 1'b1;
      if (!s_ff.wr_dir && s_ff.tgt == cmd_port_pkg::T_BUF) begin
        rb[7:0] = buf_byte(s_ff.idx);
        rb[15:8] = bus16 ? buf_byte(s_ff.idx + 11'h001) : 8'h00;
        if (s_ff.rx_full && s_ff.rx_ep == s_ff.ep &&
            {5'h00, top} >= s_ff.rx_len + 16'h0001) begin
          nxt_s.rx_full = 1'b0;
        end
        nxt_s.idx = s_ff.idx + step;
      end else if (!s_ff.wr_dir && s_ff.tgt != cmd_port_pkg::T_NONE) begin
        for (int k = 0; k < 2; k++) begin
          p = {1'b0, s_ff.idx[1:0]} + 3'(k);
          if ((k == 0 || bus16) && p < wid && s_ff.idx < 11'h004) begin
            rb[8*k +: 8] = wval[{p[1:0], 3'b000} +: 8];
          end
        end
        nxt_s.idx = s_ff.idx + step;
      end
      nxt_s.rsp.data = rb;
    end

    // OUT packet capture from the serial side
    if (rx_take) begin
      nxt_s.rx_wptr = s_ff.rx_wptr + 10'h001;
      if (rx_data.last) begin
        nxt_s.rx_full = 1'b1;
        nxt_s.rx_ep = rx_data.ep;
        nxt_s.rx_len = {6'h00, s_ff.rx_wptr} + 16'h0001;
        nxt_s.rx_wptr = 10'h000;
      end
    end

    // command phase overrides the data-phase idx, cnt and len updates
    if (req.wr && req.sel) begin
      nxt_s.tgt = tgt_of(c);
      nxt_s.wr_dir = is_wr(c);
      nxt_s.ep = c[3:0];
      nxt_s.idx = 11'h000;
      nxt_s.cnt = 16'h0000;
      nxt_s.len = 16'h0000;
      nxt_s.pend_v = 1'b0;
      if (c[7:4] == `GRP_STALL) begin
        nxt_s.tgt = cmd_port_pkg::T_NONE;
        nxt_s.stall[c[3:0]] = 1'b1;
      end
      if (c == `CMD_RESET) begin
        nxt_s = rst_state();
      end
    end

    nxt_s.bufrdy = (txq_level < LVW'(`TXQ_DEPTH - `TXQ_MARGIN)) && !nxt_s.pend_v;
    nxt_s.rxrdy = !nxt_s.rx_full;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_ff <= rst_state();
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  // OUT packet storage
  always_ff @(posedge core_clk) begin
    if (clk_en && !sys_rst && rx_take) begin
      rx_mem[s_ff.rx_wptr] <= rx_data.data;
    end
  end

  // IN byte queue toward the serial engine
  txq_fifo #(
    .WIDTH(`TXQ_WIDTH),
    .DEPTH(`TXQ_DEPTH)
  ) u_txq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_valid(push_v),
    .in_ready(),
    .in_data(push_d),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data),
    .level(txq_level)
  );

  // registered outputs
  assign rsp_ff = s_ff.rsp;
  assign buf_ready_ff = s_ff.bufrdy;
  assign rx_ready_ff = s_ff.rxrdy;
  assign cfg_ff = s_ff.cfg;
  assign stall_ff = s_ff.stall;

  // endpoint enable bits
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      ep_enable_ff[i] = s_ff.epcfg[i][`EPCFG_EN_BIT];
    end
  end
endmodule

// >>> hdl/cmd_port_defs.svh
`ifndef CMD_PORT_DEFS_SVH
`define CMD_PORT_DEFS_SVH

// command codes and code groups (upper nibble)
`define GRP_BUF_W 4'h0
`define GRP_BUF_R 4'h1
`define GRP_CFG_W 4'h2
`define GRP_CFG_R 4'h3
`define GRP_STALL 4'h4
`define GRP_GEN 4'hB
`define CMD_BUF_W_BAD 8'h00
`define CMD_BUF_R_BAD 8'h11
`define CMD_STAT0 8'h50
`define CMD_STAT1 8'h51
`define CMD_ADDR_W 8'hB6
`define CMD_ADDR_R 8'hB7
`define CMD_MODE_W 8'hB8
`define CMD_MODE_R 8'hB9
`define CMD_HW_W 8'hBA
`define CMD_HW_R 8'hBB
`define CMD_IRQ_W 8'hC2
`define CMD_IRQ_R 8'hC3
`define CMD_DMAC_W 8'hF0
`define CMD_DMAC_R 8'hF1
`define CMD_DCNT_W 8'hF2
`define CMD_DCNT_R 8'hF3
`define CMD_RESET 8'hF6

// register widths in bytes
`define W_BYTE 3'h1
`define W_HALF 3'h2
`define W_WORD 3'h4

// reset values
`define RST_EPCFG 8'h00
`define RST_ADDR 8'h00
`define RST_MODE 8'h00
`define RST_HW 16'h0000
`define RST_IRQ 32'h0000_0000
`define RST_DMAC 16'h0000
`define RST_DCNT 16'h0000

// field positions
`define EPCFG_EN_BIT 7
`define STAT_STALL_BIT 0
`define STAT_FULL_BIT 1

// buffering
`define TXQ_WIDTH 13
`define TXQ_DEPTH 32
`define TXQ_MARGIN 2
`define RXBUF_BYTES 1024
`define LEN_BYTES 11'h002

`endif

// >>> hdl/cmd_port_pkg.sv
package cmd_port_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [15:0] data;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } bus_rsp_t;

  typedef struct packed {
    logic [3:0] ep;
    logic last;
    logic [7:0] data;
  } ep_byte_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] mode;
    logic [15:0] hw;
    logic [31:0] irq;
    logic [15:0] dmac;
    logic [15:0] dcnt;
  } dev_cfg_t;

  typedef enum logic [3:0] {
    T_NONE, T_EPCFG, T_ADDR, T_MODE, T_HW, T_IRQ, T_DMAC, T_DCNT, T_STAT, T_BUF
  } tgt_t;

  typedef struct packed {
    tgt_t tgt;
    logic wr_dir;
    logic [3:0] ep;
    logic [10:0] idx;
    logic [15:0] len;
    logic [15:0] cnt;
    logic pend_v;
    logic [7:0] pend_b;
    logic [15:0][7:0] epcfg;
    logic [15:0] stall;
    dev_cfg_t cfg;
    logic rx_full;
    logic [3:0] rx_ep;
    logic [15:0] rx_len;
    logic [9:0] rx_wptr;
    bus_rsp_t rsp;
    logic bufrdy;
    logic rxrdy;
  } state_t;

endpackage

// >>> bench/cmd_port_asserts.sv
`timescale 1ns/1ps
// port checker for the command port
module cmd_port_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic bus16,
  input wire cmd_port_pkg::bus_req_t req,
  input wire cmd_port_pkg::bus_rsp_t rsp_ff,
  input wire logic buf_ready_ff,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire cmd_port_pkg::ep_byte_t tx_data,
  input wire logic rx_valid,
  input wire logic rx_ready_ff,
  input wire cmd_port_pkg::ep_byte_t rx_data,
  input wire cmd_port_pkg::dev_cfg_t cfg_ff,
  input wire logic [15:0] stall_ff,
  input wire logic [15:0] ep_enable_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic rd_t;
  logic cmd_t;
  logic dw_t;
  // taken requests
  assign rd_t = clk_en && req.rd;
  assign cmd_t = clk_en && req.wr && req.sel;
  assign dw_t = clk_en && req.wr && !req.sel;
  a_read_answer: assert property (rd_t |=> rsp_ff.valid)
    else $error("read got no answer");
  a_rsp_pulse: assert property (rsp_ff.valid && clk_en && !req.rd |=> !rsp_ff.valid)
    else $error("answer longer than one cycle");
  a_stall_set: assert property (cmd_t && req.data[7:4] == 4'h4
    |=> stall_ff[$past(req.data[3:0])])
    else $error("stall bit not set");
  a_dev_reset: assert property (cmd_t && req.data[7:0] == 8'hF6
    |=> cfg_ff == '0 && stall_ff == '0 && ep_enable_ff == '0)
    else $error("device reset incomplete");
  a_addr_write: assert property (cmd_t && req.data[7:0] == 8'hB6 ##2 dw_t
    |=> cfg_ff.addr == $past(req.data[7:0]))
    else $error("address not written");
  a_hw_word: assert property (cmd_t && req.data[7:0] == 8'hBA ##2 dw_t && bus16
    |=> cfg_ff.hw == $past(req.data))
    else $error("hw config word not written");
  a_ep_enable: assert property (cmd_t && req.data[7:4] == 4'h2 ##2 dw_t
    |=> ep_enable_ff[$past(req.data[3:0], 3)] == $past(req.data[7]))
    else $error("endpoint enable wrong");
  a_tx_hold: assert property (tx_valid && !tx_ready && clk_en
    |=> tx_valid && $stable(tx_data))
    else $error("IN byte dropped while stalled");
  a_rx_block: assert property (rx_valid && rx_ready_ff && rx_data.last && clk_en
    |=> !rx_ready_ff)
    else $error("OUT store not closed");
  a_rst_state: assert property (@(posedge core_clk) disable iff (1'b0) sys_rst && clk_en
    |=> !rsp_ff.valid && buf_ready_ff && rx_ready_ff && !tx_valid && cfg_ff == '0)
    else $error("reset state wrong");
  c_read: cover property (rd_t ##1 rsp_ff.valid);
  c_stall: cover property (stall_ff[15]);
  c_last: cover property (tx_valid && tx_ready && tx_data.last);
  c_full: cover property (!buf_ready_ff);
endmodule
bind usb_device_command_port cmd_port_asserts u_cmd_port_asserts (.core_clk(core_clk),
  .sys_rst(sys_rst), .clk_en(clk_en), .bus16(bus16), .req(req), .rsp_ff(rsp_ff),
  .buf_ready_ff(buf_ready_ff), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .rx_valid(rx_valid), .rx_ready_ff(rx_ready_ff), .rx_data(rx_data), .cfg_ff(cfg_ff),
  .stall_ff(stall_ff), .ep_enable_ff(ep_enable_ff));

// >>> bench/serial_engine_model.sv
`timescale 1ns/1ps
// far-side serial engine: sinks IN bytes, sources OUT bytes
module serial_engine_model (
  input wire logic core_clk,
  input wire logic hold,
  input wire logic slow,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire cmd_port_pkg::ep_byte_t tx_data,
  output logic rx_valid,
  input wire logic rx_ready_ff,
  output cmd_port_pkg::ep_byte_t rx_data
);
  cmd_port_pkg::ep_byte_t got[$];
  cmd_port_pkg::ep_byte_t rx_q[$];
  logic ph = 1'b0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = '0;
  end
  // ready pattern, OUT bytes held until taken, idle data toggles
  always @(negedge core_clk) begin
    ph <= !ph;
    tx_ready <= !hold && (!slow || ph);
    rx_valid <= rx_q.size() > 0;
    rx_data <= rx_q.size() > 0 ? rx_q[0] : ~rx_data;
  end
  // handshakes on the rising edge
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (rx_valid && rx_ready_ff) void'(rx_q.pop_front());
  end
endmodule

// >>> bench/usb_device_command_port_tb.sv
`timescale 1ns/1ps
module usb_device_command_port_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bus16 = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic clk_en = 1'b1;
  cmd_port_pkg::bus_req_t req = '0;
  cmd_port_pkg::bus_rsp_t rsp_ff;
  cmd_port_pkg::ep_byte_t tx_data;
  cmd_port_pkg::ep_byte_t rx_data;
  cmd_port_pkg::dev_cfg_t cfg_ff;
  logic buf_ready_ff, tx_valid, tx_ready, rx_valid, rx_ready_ff;
  logic [15:0] stall_ff, ep_enable_ff;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 core_clk = ~core_clk;
  usb_device_command_port u_usb_device_command_port (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .bus16(bus16), .req(req), .rsp_ff(rsp_ff), .buf_ready_ff(buf_ready_ff),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready_ff(rx_ready_ff), .rx_data(rx_data), .cfg_ff(cfg_ff), .stall_ff(stall_ff),
    .ep_enable_ff(ep_enable_ff));
  serial_engine_model u_serial_engine_model (.core_clk(core_clk), .hold(hold), .slow(slow),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready_ff(rx_ready_ff), .rx_data(rx_data));
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one write strobe, released a cycle later
  task automatic put(input logic s, input logic [15:0] d);
    @(negedge core_clk);
    req = '{wr: 1'b1, rd: 1'b0, sel: s, data: d};
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask
  // one read strobe, answer sampled the cycle after it is taken
  task automatic get(output logic [15:0] d);
    @(negedge core_clk);
    req = '{wr: 1'b0, rd: 1'b1, sel: 1'b0, data: 16'h0000};
    @(negedge core_clk);
    req.rd = 1'b0;
    d = rsp_ff.data;
    chk(rsp_ff.valid, 1);
  endtask
  // wait for k IN bytes, then a quiet spell
  task automatic drain(input int k);
    for (int n = 0; n < 400 && u_serial_engine_model.got.size() < k; n++) @(negedge core_clk);
    repeat (20) @(negedge core_clk);
    chk(u_serial_engine_model.got.size(), k);
  endtask
  // every config register in both widths, after a write of 16'hFFFF
  task automatic t_regs();
    logic [7:0] wc[6] = '{8'hB6, 8'hB8, 8'hBA, 8'hC2, 8'hF0, 8'hF2};
    int nb[6] = '{1, 1, 2, 4, 2, 2};
    logic [31:0] v;
    logic [15:0] d;
    int w;
    for (int m = 0; m < 2; m++) begin
      bus16 <= m[0];
      w = m + 1;
      for (int i = 0; i < 6; i++) begin
        v = (32'h8C4A_E713 + 32'(i * 16'h1111 + m)) & ~(32'hFFFF_FFFF << (8 * nb[i]));
        put(1'b1, {8'hA5, wc[i]});
        put(1'b0, 16'hFFFF);
        put(1'b1, {8'h00, wc[i]});
        for (int k = 0; k < (nb[i] + w - 1) / w; k++)
          put(1'b0, 16'(v >> (8 * w * k)) | (nb[i] == 1 ? 16'hC300 : 16'h0000));
        put(1'b1, {8'h00, wc[i] + 8'h01});
        for (int k = 0; k < (nb[i] + w - 1) / w; k++) begin
          get(d);
          chk(d & (m ? 16'hFFFF : 16'h00FF), 16'(v >> (8 * w * k)) & (m ? 16'hFFFF : 16'h00FF));
        end
      end
    end
    $display("t_regs done");
  endtask
  // endpoint config, stall and status, then device reset
  task automatic t_ep();
    logic [15:0] d;
    logic [15:0] en;
    bus16 <= 1'b0;
    for (int e = 0; e < 16; e++) begin
      put(1'b1, {8'h00, 4'h2, 4'(e)});
      put(1'b0, {8'h00, 8'(e * 8'h17)});
      en[e] = 1'(8'(e * 8'h17) >> 7);
      put(1'b1, {8'h00, 4'h4, 4'(e)});
      chk(stall_ff[e], 1);
      put(1'b1, {8'h00, 4'h3, 4'(e)});
      get(d);
      chk(d[7:0], 8'(e * 8'h17));
    end
    chk(ep_enable_ff, en);
    for (int s = 0; s < 2; s++) begin
      put(1'b1, {8'h00, 8'h50 + 8'(s)});
      get(d);
      chk(d[7:0], 8'h01);
    end
    // frozen core must ignore a device reset
    clk_en <= 1'b0;
    put(1'b1, 16'h00F6);
    chk(stall_ff[0], 1);
    clk_en <= 1'b1;
    bus16 <= 1'b1;
    put(1'b1, 16'h3CF6);
    chk(|{cfg_ff, stall_ff, ep_enable_ff}, 0);
    $display("t_ep done");
  endtask
  // IN packets: fifo filled against a stalled far side, then odd 16-bit length
  task automatic t_in();
    logic full;
    full = 1'b0;
    bus16 <= 1'b0;
    hold <= 1'b1;
    put(1'b1, 16'h0022);
    put(1'b0, 16'h0080);
    put(1'b1, 16'h0002);
    put(1'b0, 16'h0028);
    put(1'b0, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      for (int n = 0; n < 100 && buf_ready_ff !== 1'b1; n++) begin
        full = 1'b1;
        hold <= 1'b0;
        @(negedge core_clk);
      end
      put(1'b0, {8'h00, 8'(i)});
    end
    drain(40);
    chk(full, 1);
    for (int i = 0; i < 40; i++)
      chk(u_serial_engine_model.got[i], {4'h2, i == 39, 8'(i)});
    u_serial_engine_model.got.delete();
    bus16 <= 1'b1;
    slow <= 1'b1;
    put(1'b1, 16'h0021);
    put(1'b0, 16'h0080);
    put(1'b1, 16'h0001);
    put(1'b0, 16'h0003);
    put(1'b0, 16'hBBAA);
    put(1'b0, 16'h77CC);
    drain(3);
    for (int i = 0; i < 3; i++)
      chk(u_serial_engine_model.got[i], {4'h1, i == 2, 8'hAA + 8'(i * 17)});
    $display("t_in done");
  endtask
  // OUT packet from the far side, read back as words
  task automatic t_out();
    logic [15:0] d;
    bus16 <= 1'b1;
    for (int i = 0; i < 3; i++)
      u_serial_engine_model.rx_q.push_back(cmd_port_pkg::ep_byte_t'({4'h0, i == 2,
        8'(8'h11 * (i + 1))}));
    for (int n = 0; n < 100 && rx_ready_ff !== 1'b0; n++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    chk(rx_ready_ff, 0);
    put(1'b1, 16'h0050);
    get(d);
    chk(d, 16'h0002);
    put(1'b1, 16'h0010);
    get(d);
    chk(d, 16'h0003);
    get(d);
    chk(d, 16'h2211);
    get(d);
    chk(d[7:0], 8'h33);
    @(negedge core_clk);
    chk(rx_ready_ff, 1);
    $display("t_out done");
  endtask
  // hang guard, sized well beyond the sequence
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  // reset, then the scenarios
  initial begin
    repeat (6) @(negedge core_clk);
    chk({rsp_ff.valid, buf_ready_ff, rx_ready_ff, tx_valid}, 4'b0110);
    chk(|{cfg_ff, stall_ff, ep_enable_ff}, 0);
    sys_rst = 1'b0;
    t_regs();
    t_ep();
    t_in();
    t_out();
    close_out();
  end
endmodule
